// ===== ircp_regs.v
// Carrier period registers and carrier generator with APB slave
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ircp_map.vh"
// What this block does
// - Debug mode freezes all carrier counting
// - Primary high count register, eight bits
// - Primary low count register, eight bits
// - Secondary high count register, eight bits
// - Secondary low count register, eight bits
// - Time mode always uses primary pair
// - Time mode never uses secondary pair
// - Shift mode alternates pairs under modulator
// - Reset keeps primary counts unchanged
// - Reset keeps secondary counts unchanged
// - In shift mode, pair toggles at each space expiry while counting runs, once on resume for all expiries held while frozen
// - Counting tick is module clock divided 1/2/4/8
module ircp_regs
(
  // Clock and reset
  input wire i_mclk,
  input wire i_rst_b,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  // Debug and modulator
  input wire i_debug_active,
  input wire i_space_expired,
  // Carrier
  output reg o_carrier,
  output reg o_sec_selected
);
  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  // Count registers, no reset
  reg [7:0] pri_high_value_q;
  reg [7:0] pri_low_value_q;
  reg [7:0] sec_high_value_q;
  reg [7:0] sec_low_value_q;
  // Control
  reg modulator_carrier_enable_q;
  reg freq_shift_mode_q;
  reg [1:0] clock_prescale_sel_q;
  // Synchronisers
  reg dbg_s1_q;
  reg dbg_s2_q;
  reg spc_s1_q;
  reg spc_s2_q;
  reg spc_s3_q;
  reg space_pend_q;
  // Generator
  reg [7:0] cnt_q;
  reg sec_q;
  wire tick;
  wire run;
  wire space_edge;
  wire wr_en;
  reg [7:0] high_sel;
  reg [7:0] low_sel;
  reg [31:0] rdata_d;
  reg hit_d;
  // Per-register write strobes
  wire wr_pri_high;
  wire wr_pri_low;
  wire wr_sec_high;
  wire wr_sec_low;
  wire wr_ctrl;
  // Generator next values
  reg [7:0] cnt_d;
  reg sec_d;
  reg pend_d;
  reg carrier_d;
  reg sec_sel_d;

  // ------------------------------------------------------------------
  // Input synchronisers and decode
  // ------------------------------------------------------------------
  // Bus strobe for the access phase
  assign wr_en = i_psel & i_penable & i_pwrite;
  // Write strobes; status and unmapped offsets are never written
  assign wr_pri_high = wr_en & (i_paddr == `IRCP_OFF_PRI_HIGH);
  assign wr_pri_low = wr_en & (i_paddr == `IRCP_OFF_PRI_LOW);
  assign wr_sec_high = wr_en & (i_paddr == `IRCP_OFF_SEC_HIGH);
  assign wr_sec_low = wr_en & (i_paddr == `IRCP_OFF_SEC_LOW);
  assign wr_ctrl = wr_en & (i_paddr == `IRCP_OFF_CTRL);
  assign run = modulator_carrier_enable_q & ~dbg_s2_q;
  // Rising edge of the synchronised expiry
  assign space_edge = spc_s2_q & ~spc_s3_q;

  // Debug level synchroniser, two flops
  always @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      dbg_s1_q <= 1'b0;
      dbg_s2_q <= 1'b0;
    end
    else
    begin
      dbg_s1_q <= i_debug_active;
      dbg_s2_q <= dbg_s1_q;
    end
  end

  // Expiry synchroniser plus edge history flop
  always @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      spc_s1_q <= 1'b0;
      spc_s2_q <= 1'b0;
      spc_s3_q <= 1'b0;
    end
    else
    begin
      spc_s1_q <= i_space_expired;
      spc_s2_q <= spc_s1_q;
      spc_s3_q <= spc_s2_q;
    end
  end

  ircp_prescale u_pre
  (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_run(run),
    .i_sel(clock_prescale_sel_q),
    .o_tick(tick)
  );

  // ------------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------------
  // Count registers written by software, never reset
  always @(posedge i_mclk)
  begin
    if (wr_pri_high)
      pri_high_value_q <= i_pwdata[7:0];
    if (wr_pri_low)
      pri_low_value_q <= i_pwdata[7:0];
    if (wr_sec_high)
      sec_high_value_q <= i_pwdata[7:0];
    if (wr_sec_low)
      sec_low_value_q <= i_pwdata[7:0];
  end

  // Control register
  always @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      modulator_carrier_enable_q <= 1'b0;
      freq_shift_mode_q <= 1'b0;
      clock_prescale_sel_q <= `IRCP_DIV_1;
    end
    else if (wr_ctrl)
    begin
      modulator_carrier_enable_q <= i_pwdata[`IRCP_CTRL_EN];
      freq_shift_mode_q <= i_pwdata[`IRCP_CTRL_SHIFT];
      clock_prescale_sel_q <= i_pwdata[`IRCP_CTRL_DIV_HI:`IRCP_CTRL_DIV_LO];
    end
  end

  // ------------------------------------------------------------------
  // Carrier generator
  // ------------------------------------------------------------------
  // Pair selection mux
  always @*
  begin
    if (freq_shift_mode_q && sec_q)
    begin
      high_sel = sec_high_value_q;
      low_sel = sec_low_value_q;
    end
    else
    begin
      high_sel = pri_high_value_q;
      low_sel = pri_low_value_q;
    end
  end

  // Carrier generator and pair toggle, next values
  always @*
  begin
    cnt_d = cnt_q;
    sec_d = sec_q;
    pend_d = space_pend_q;
    carrier_d = o_carrier;
    sec_sel_d = freq_shift_mode_q & sec_q;
    if (!modulator_carrier_enable_q)
    begin
      // Disable parks the generator on the primary pair
      cnt_d = `IRCP_CNT_ONE;
      sec_d = 1'b0;
      pend_d = 1'b0;
      carrier_d = 1'b0;
      sec_sel_d = 1'b0;
    end
    else
    begin
      // Expiry held until counting runs
      if (space_edge && !run)
        pend_d = 1'b1;
      if (run)
      begin
        if ((space_edge || space_pend_q) && freq_shift_mode_q)
          sec_d = ~sec_q;
        pend_d = 1'b0;
      end
      if (run && tick)
      begin
        if (cnt_q <= `IRCP_CNT_ONE)
        begin
          carrier_d = ~o_carrier;
          cnt_d = o_carrier ? low_sel : high_sel;
        end
        else
          cnt_d = cnt_q - `IRCP_CNT_ONE;
      end
    end
  end

  // Generator registers
  always @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      cnt_q <= `IRCP_CNT_ONE;
      sec_q <= 1'b0;
      space_pend_q <= 1'b0;
      o_carrier <= 1'b0;
      o_sec_selected <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      sec_q <= sec_d;
      space_pend_q <= pend_d;
      o_carrier <= carrier_d;
      o_sec_selected <= sec_sel_d;
    end
  end

  // ------------------------------------------------------------------
  // Read path and bus answer
  // ------------------------------------------------------------------
  // Read mux and decode
  always @*
  begin
    rdata_d = `IRCP_ZERO32;
    hit_d = 1'b1;
    case (i_paddr)
      `IRCP_OFF_PRI_HIGH: rdata_d[7:0] = pri_high_value_q;
      `IRCP_OFF_PRI_LOW: rdata_d[7:0] = pri_low_value_q;
      `IRCP_OFF_SEC_HIGH: rdata_d[7:0] = sec_high_value_q;
      `IRCP_OFF_SEC_LOW: rdata_d[7:0] = sec_low_value_q;
      `IRCP_OFF_CTRL:
      begin
        rdata_d[`IRCP_CTRL_EN] = modulator_carrier_enable_q;
        rdata_d[`IRCP_CTRL_SHIFT] = freq_shift_mode_q;
        rdata_d[`IRCP_CTRL_DIV_HI:`IRCP_CTRL_DIV_LO] = clock_prescale_sel_q;
      end
      `IRCP_OFF_STATUS:
      begin
        rdata_d[`IRCP_ST_OUT] = o_carrier;
        rdata_d[`IRCP_ST_SEC] = o_sec_selected;
        rdata_d[`IRCP_ST_FROZEN] = dbg_s2_q;
      end
      default: hit_d = 1'b0;
    endcase
  end

  // APB answer, zero wait states
  always @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      o_prdata <= `IRCP_ZERO32;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~hit_d;
      // Read data stands for the access cycle only
      if (i_psel && !i_penable && !i_pwrite)
        o_prdata <= rdata_d;
      else
        o_prdata <= `IRCP_ZERO32;
    end
  end
endmodule

// ===== ircp_map.vh
// Register offsets, field positions and constants for the carrier period block
`ifndef IRCP_MAP_VH
`define IRCP_MAP_VH
`define IRCP_OFF_PRI_HIGH 12'h000
`define IRCP_OFF_PRI_LOW 12'h004
`define IRCP_OFF_SEC_HIGH 12'h008
`define IRCP_OFF_SEC_LOW 12'h00c
`define IRCP_OFF_CTRL 12'h010
`define IRCP_OFF_STATUS 12'h014
`define IRCP_CTRL_EN 0
`define IRCP_CTRL_SHIFT 1
`define IRCP_CTRL_DIV_LO 2
`define IRCP_CTRL_DIV_HI 3
`define IRCP_ST_OUT 0
`define IRCP_ST_SEC 1
`define IRCP_ST_FROZEN 2
`define IRCP_DIV_1 2'h0
`define IRCP_DIV_2 2'h1
`define IRCP_DIV_4 2'h2
`define IRCP_DIV_8 2'h3
`define IRCP_PRE_MAX1 3'h0
`define IRCP_PRE_MAX2 3'h1
`define IRCP_PRE_MAX4 3'h3
`define IRCP_PRE_MAX8 3'h7
`define IRCP_CNT_ONE 8'h01
`define IRCP_ZERO32 32'h00000000
`endif

// ===== ircp_prescale.v
// Module clock prescaler producing a one-cycle enable pulse
`timescale 1ns/1ps
`include "ircp_map.vh"
module ircp_prescale
(
  // Clock and reset
  input wire i_mclk,
  input wire i_rst_b,
  // Control
  input wire i_run,
  input wire [1:0] i_sel,
  // Enable out
  output reg o_tick
);
  reg [2:0] cnt_q;
  reg [2:0] max_w;

  // Terminal count from select code
  always @*
  begin
    case (i_sel)
      `IRCP_DIV_1: max_w = `IRCP_PRE_MAX1;
      `IRCP_DIV_2: max_w = `IRCP_PRE_MAX2;
      `IRCP_DIV_4: max_w = `IRCP_PRE_MAX4;
      default: max_w = `IRCP_PRE_MAX8;
    endcase
  end

  // Divider counter, held while frozen
  always @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      cnt_q <= 3'h0;
      o_tick <= 1'b0;
    end
    else if (!i_run)
    begin
      o_tick <= 1'b0;
    end
    else if (cnt_q >= max_w)
    begin
      cnt_q <= 3'h0;
      o_tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 3'h1;
      o_tick <= 1'b0;
    end
  end
endmodule

// ===== ircp_regs_asserts.sv
// Port assertions for the carrier period block
`timescale 1ns/1ps
module ircp_chk
(
  // Watched ports
  input wire i_mclk,
  input wire i_rst_b,
  input wire i_psel,
  input wire i_penable,
  input wire [11:0] i_paddr,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire i_debug_active,
  input wire o_carrier,
  input wire o_sec_selected
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  property p_rdy; i_psel && !i_penable |=> o_pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_one; o_pready |=> !o_pready; endproperty
  a_one: assert property (p_one) else $error("ready held");
  property p_err; i_psel && !i_penable && i_paddr > 12'h014 |=> o_pslverr; endproperty
  a_err: assert property (p_err) else $error("no error");
  property p_slv; o_pslverr |-> o_pready; endproperty
  a_slv: assert property (p_slv) else $error("stray error");
  property p_idle; !o_pready |-> o_prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("data idle");
  property p_up; o_pready |-> o_prdata[31:8] == 24'h0; endproperty
  a_up: assert property (p_up) else $error("upper bits");
  property p_frz; i_debug_active [*4] |=> $stable(o_carrier); endproperty
  a_frz: assert property (p_frz) else $error("carrier ran");
  property p_frs; i_debug_active [*4] |=> $stable(o_sec_selected); endproperty
  a_frs: assert property (p_frs) else $error("pair ran");
endmodule
bind ircp_regs ircp_chk u_chk
(
  .i_mclk(i_mclk),
  .i_rst_b(i_rst_b),
  .i_psel(i_psel),
  .i_penable(i_penable),
  .i_paddr(i_paddr),
  .o_prdata(o_prdata),
  .o_pready(o_pready),
  .o_pslverr(o_pslverr),
  .i_debug_active(i_debug_active),
  .o_carrier(o_carrier),
  .o_sec_selected(o_sec_selected)
);

// ===== ircp_regs_bench.sv
// Self-checking bench for the carrier period block
`timescale 1ns/1ps
module ircp_regs_bench;
  reg i_mclk = 1'h0, i_rst_b = 1'h0, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
  reg i_debug_active = 1'h0, i_space_expired = 1'h0, err_q, h_q;
  reg [11:0] i_paddr = 12'h0;
  reg [31:0] i_pwdata = 32'h0, rd_q, tab = 32'h01050302;
  wire [31:0] o_prdata;
  wire o_pready, o_pslverr, o_carrier, o_sec_selected;
  integer miscompares = 0, checked = 0, cyc = 0, hi, lo, k;
  // Clock
  initial
  begin
    forever #2.5 i_mclk = ~i_mclk;
  end
  ircp_regs dut
  (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .i_debug_active(i_debug_active),
    .i_space_expired(i_space_expired),
    .o_carrier(o_carrier),
    .o_sec_selected(o_sec_selected)
  );
  // Verdict
  task results;
  begin
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  // Compare
  task chk(input [32:0] g, input [32:0] e);
  begin
    checked = checked + 1;
    if (g !== e)
    begin
      miscompares = miscompares + 1;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  end
  endtask
  // APB transfer, held until ready
  task xfer(input w, input [11:0] a, input [31:0] d);
  begin
    @(posedge i_mclk);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'h1;
    do @(posedge i_mclk); while (o_pready !== 1'h1);
    rd_q = o_prdata;
    err_q = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
  end
  endtask
  task rd(input [11:0] a, input [31:0] e, input se);
  begin
    xfer(1'h0, a, 32'h0);
    chk({err_q, rd_q}, {se, e});
  end
  endtask
  // Space expiry pulse, then settle
  task sp;
  begin
    i_space_expired <= 1'h1;
    repeat (3) @(posedge i_mclk);
    i_space_expired <= 1'h0;
    repeat (40) @(posedge i_mclk);
  end
  endtask
  // Measure one full high and low run
  task meas;
  begin
    while (o_carrier !== 1'h0) @(posedge i_mclk);
    while (o_carrier !== 1'h1) @(posedge i_mclk);
    hi = 0;
    lo = 0;
    while (o_carrier === 1'h1)
    begin
      hi = hi + 1;
      @(posedge i_mclk);
    end
    while (o_carrier === 1'h0)
    begin
      lo = lo + 1;
      @(posedge i_mclk);
    end
  end
  endtask
  // Timeout
  always @(posedge i_mclk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      miscompares = miscompares + 1;
      results;
    end
  end
  // Main sequence
  initial
  begin
    repeat (12) @(posedge i_mclk);
    i_rst_b <= 1'h1;
    for (k = 0; k < 4; k = k + 1)
      xfer(1'h1, k * 4, 32'hffffff00 | tab[8*k +: 8]);
    for (k = 0; k < 4; k = k + 1) rd(k * 4, tab[8*k +: 8], 1'h0);
    rd(12'h020, 32'h0, 1'h1);
    @(posedge i_mclk);
    i_rst_b <= 1'h0;
    repeat (4) @(posedge i_mclk);
    i_rst_b <= 1'h1;
    for (k = 0; k < 4; k = k + 1) rd(k * 4, tab[8*k +: 8], 1'h0);
    xfer(1'h1, 12'h010, 32'h1);
    sp;
    meas;
    chk(hi, 2);
    chk(lo, 3);
    chk(o_sec_selected, 1'h0);
    xfer(1'h1, 12'h010, 32'h3);
    sp;
    meas;
    chk(hi, 5);
    chk(lo, 1);
    chk(o_sec_selected, 1'h1);
    sp;
    meas;
    chk(hi, 2);
    chk(lo, 3);
    chk(o_sec_selected, 1'h0);
    for (k = 0; k < 4; k = k + 1)
    begin
      xfer(1'h1, 12'h010, 32'h0);
      xfer(1'h1, 12'h010, (k << 2) | 1);
      meas;
      chk(hi, 2 << k);
      chk(lo, 3 << k);
    end
    rd(12'h010, 32'hd, 1'h0);
    i_debug_active <= 1'h1;
    repeat (4) @(posedge i_mclk);
    h_q = o_carrier;
    rd(12'h014, {29'h0, 2'h2, h_q}, 1'h0);
    for (k = 0; k < 45; k = k + 1)
    begin
      @(posedge i_mclk);
      chk(o_carrier, h_q);
    end
    i_debug_active <= 1'h0;
    meas;
    chk(hi, 16);
    results;
  end
endmodule
